/* src/bcs_debounce.sv */
// Synchroniser and debounce filter for the control inputs
`timescale 1ns/1ps
module bcs_debounce #(
  parameter int DEB_CYC = bcs_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Filtered levels
  bcs_filt_if.filt  fi
);
  localparam int N  = bcs_pkg::NUM_CTRL;
  localparam int DW = 20; // Settle counter width per lane

  // Elaboration-time limit: the settle count must fit its counter
  if (DEB_CYC < 1 || DEB_CYC >= (1 << DW)) begin : g_bad_deb
    $error("DEB_CYC out of range");
  end

  // All state in one struct
  typedef struct packed {
    logic [N-1:0]       s1;      // First sync stage, read only by s2
    logic [N-1:0]       s2;      // Second sync stage
    logic [N-1:0]       stable;  // Accepted level
    logic [N*DW-1:0]    cnt;     // Per-lane settle counters
  } bcs_deb_t;

  bcs_deb_t st_reg;  // Registered state
  bcs_deb_t st_next; // Next state

  // --------------------------------------------------------------------------
  // Per-lane settle counting
  // --------------------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = fi.raw_n;
    st_next.s2 = st_reg.s1;
    for (int i = 0; i < N; i++) begin
      // Level must hold steady a full settle time before accepted
      if (st_reg.s2[i] == st_reg.stable[i]) begin
        st_next.cnt[i*DW +: DW] = '0;
      end else if (st_reg.cnt[i*DW +: DW] == DW'(DEB_CYC - 1)) begin
        st_next.stable[i]       = st_reg.s2[i];
        st_next.cnt[i*DW +: DW] = '0;
      end else begin
        st_next.cnt[i*DW +: DW] = st_reg.cnt[i*DW +: DW] + DW'(1);
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg        <= '0;
      st_reg.s1     <= bcs_pkg::CTRL_IDLE;
      st_reg.s2     <= bcs_pkg::CTRL_IDLE;
      st_reg.stable <= bcs_pkg::CTRL_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fi.stable_n = st_reg.stable;
endmodule : bcs_debounce

/* src/bcs_filt_if.sv */
// Interface carrying filtered control levels from debouncer to sequencer
`timescale 1ns/1ps
interface bcs_filt_if;
  logic [bcs_pkg::NUM_CTRL-1:0] raw_n;    // Raw active-low levels
  logic [bcs_pkg::NUM_CTRL-1:0] stable_n; // Debounced active-low levels
  modport filt (input raw_n, output stable_n);
  modport user (output raw_n, input stable_n);
endinterface : bcs_filt_if

/* src/bcs_pkg.sv */
// Package of constants and types for the control input sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package bcs_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000; // System clock rate
  localparam int SHORT_PRESS_MS  = 200;        // Least press for an action
  localparam int LONG_PRESS_MS   = 2000;       // Hard shutdown threshold
  localparam int DEBOUNCE_US     = 5000;       // Bounce settle time
  // Times scale to whole cycles; clock per unit truncates, no lower bound
  localparam int SHORT_PRESS_CYC = (SHORT_PRESS_MS * (CLK_HZ / 1000));
  localparam int LONG_PRESS_CYC  = (LONG_PRESS_MS * (CLK_HZ / 1000));
  localparam int DEBOUNCE_CYC    = (DEBOUNCE_US * (CLK_HZ / 1000_000));
  localparam int CNT_W           = 26;         // Press counter width

  // --------------------------------------------------------------------------
  // Widths and reset values
  // --------------------------------------------------------------------------
  localparam int GP_COUNT        = 4;          // General inputs and outputs
  localparam int NUM_CTRL        = 4;          // Control inputs filtered
  localparam int IDX_FCLR        = 0;          // Fault-clear lane
  localparam int IDX_FRST        = 1;          // Factory-reset lane
  localparam int IDX_SHDN        = 2;          // Shutdown lane
  localparam int IDX_WAKE        = 3;          // Wake lane
  localparam logic [NUM_CTRL-1:0] CTRL_IDLE = 4'hf;    // All released (high)

  // --------------------------------------------------------------------------
  // Shutdown sequence states, Gray along the usual path
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SQ_RUN   = 3'h0,  // Powered, normal service
    SQ_REQ   = 3'h1,  // Disconnect requested of stack control
    SQ_STACK = 3'h3,  // Waiting stack disconnect done
    SQ_CONT  = 3'h2,  // Waiting contactors open
    SQ_OFF   = 3'h6   // Power removed
  } bcs_seq_t;

endpackage : bcs_pkg

/* src/bcs_sequencer.sv */
// Control input sequencer: fault clear, shutdown, factory reset and wake
`timescale 1ns/1ps
module bcs_sequencer #(
  parameter int SHORT_CYC = bcs_pkg::SHORT_PRESS_CYC,
  parameter int LONG_CYC  = bcs_pkg::LONG_PRESS_CYC,
  parameter int DEB_CYC   = bcs_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset,
  // Control inputs, active low contact closures
  input  wire logic                         fault_clear_n,
  input  wire logic                         factory_reset_n,
  input  wire logic                         shutdown_n,
  input  wire logic                         unit_wake_n,
  // System status
  input  wire logic                         startup,
  input  wire logic                         faults_active,
  input  wire logic                         close_pending,
  input  wire logic                         stack_disc_done,
  input  wire logic                         contactors_open,
  input  wire logic                         service_lockout,
  input  wire logic                         lockout_exit,
  // General-purpose isolated I/O
  input  wire logic [bcs_pkg::GP_COUNT-1:0] gp_in_k,
  input  wire logic [bcs_pkg::GP_COUNT-1:0] gp_out_set,
  // Outputs
  output logic                              clear_fault,
  output logic                              close_permit,
  output logic                              auto_close,
  output logic                              stack_disc_req,
  output logic                              power_enable,
  output logic                              hard_power_cut,
  output logic                              factory_load,
  output logic                              config_erase,
  output logic [bcs_pkg::GP_COUNT-1:0]      gp_out_a,
  output logic [bcs_pkg::GP_COUNT-1:0]      gp_in_seen
);
  localparam int CW = bcs_pkg::CNT_W;

  // Elaboration-time limits
  // Press counter must reach the long threshold without wrapping
  if (SHORT_CYC < 1 || LONG_CYC <= SHORT_CYC || LONG_CYC >= (1 << CW)) begin : g_bad_press
    $error("press thresholds out of range");
  end

  // --------------------------------------------------------------------------
  // Debounce of the four control inputs
  // --------------------------------------------------------------------------
  bcs_filt_if fi ();
  assign fi.raw_n = {unit_wake_n, shutdown_n, factory_reset_n, fault_clear_n};

  bcs_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
    .mclk  (mclk),
    .reset (reset),
    .fi    (fi.filt)
  );

  // Low level means closed to the reference
  logic fclr_on, frst_on, shdn_on, wake_on;
  assign fclr_on = ~fi.stable_n[bcs_pkg::IDX_FCLR];
  assign frst_on = ~fi.stable_n[bcs_pkg::IDX_FRST];
  assign shdn_on = ~fi.stable_n[bcs_pkg::IDX_SHDN];
  assign wake_on = ~fi.stable_n[bcs_pkg::IDX_WAKE];

  // --------------------------------------------------------------------------
  // State of the sequencer
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0]                fcnt;      // Fault-clear press length
    logic                         fdone;     // Clear issued this press
    logic [CW-1:0]                scnt;      // Shutdown press length
    logic                         shold;     // Shutdown press in progress
    bcs_pkg::bcs_seq_t            seq;       // Shutdown sequence state
    logic                         clr_wait;  // Judge faults after clear
    logic                         clear;     // Clear pulse
    logic                         permit;    // Closure allowed
    logic                         auto_cl;   // Auto-close pulse
    logic                         disc_req;  // Stack disconnect request
    logic                         pwr;       // Power held on
    logic                         hcut;      // Hardware cut latched
    logic                         fload;     // Factory image load
    logic                         erase;     // Config erase
    logic [bcs_pkg::GP_COUNT-1:0] gpo;       // General outputs
    logic [bcs_pkg::GP_COUNT-1:0] gpi;       // General input detectors
  } bcs_seq_state_t;

  bcs_seq_state_t st_reg;  // Registered state
  bcs_seq_state_t st_next; // Next state

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic shut_go; // Graceful shutdown starts this cycle
    shut_go  = 1'b0;
    st_next  = st_reg;
    st_next.clear   = 1'b0;
    st_next.auto_cl = 1'b0;

    // Isolated general I/O, one bit per channel
    st_next.gpo = gp_out_set;
    st_next.gpi = ~gp_in_k;

    // Fault clear: one clear per press once held long enough
    if (fclr_on) begin
      if (!st_reg.fdone && st_reg.fcnt == CW'(SHORT_CYC - 1)) begin
        st_next.clear    = 1'b1;
        st_next.fdone    = 1'b1;
        st_next.clr_wait = 1'b1;
      end else if (!st_reg.fdone) begin
        st_next.fcnt = st_reg.fcnt + CW'(1);
      end
    end else begin
      st_next.fcnt  = '0;
      st_next.fdone = 1'b0;
    end

    // In the cycle of the clear pulse, judge what faults remain
    if (st_reg.clr_wait) begin
      st_next.clr_wait = 1'b0;
      if (!faults_active) begin
        st_next.permit  = 1'b1;
        st_next.auto_cl = close_pending;
      end else begin
        st_next.permit  = 1'b0;
      end
    end else if (faults_active) begin
      st_next.permit = 1'b0;
    end

    // Shutdown press timing; release decides short versus long
    if (shdn_on) begin
      st_next.shold = 1'b1;
      if (st_reg.scnt != CW'(LONG_CYC)) begin
        st_next.scnt = st_reg.scnt + CW'(1);
      end
      // Beyond the long threshold hardware cuts power alone
      if (st_reg.scnt == CW'(LONG_CYC - 1) && !wake_on) begin
        st_next.hcut = 1'b1;
      end
    end else begin
      st_next.shold = 1'b0;
      st_next.scnt  = '0;
      if (st_reg.shold && st_reg.scnt >= CW'(SHORT_CYC)
          && st_reg.scnt < CW'(LONG_CYC)) begin
        shut_go = 1'b1;
      end
    end

    // Graceful shutdown sequence
    unique case (st_reg.seq)
      bcs_pkg::SQ_RUN: begin
        if (shut_go && (service_lockout || lockout_exit)) begin
          st_next.seq = bcs_pkg::SQ_OFF;
        end else if (shut_go) begin
          st_next.seq      = bcs_pkg::SQ_REQ;
          st_next.disc_req = 1'b1;
        end
      end
      bcs_pkg::SQ_REQ: begin
        st_next.seq = bcs_pkg::SQ_STACK;
      end
      bcs_pkg::SQ_STACK: begin
        if (service_lockout || lockout_exit) begin
          st_next.seq = bcs_pkg::SQ_OFF;
        end else if (stack_disc_done) begin
          st_next.seq = bcs_pkg::SQ_CONT;
        end
      end
      bcs_pkg::SQ_CONT: begin
        if (contactors_open || service_lockout || lockout_exit) begin
          st_next.seq = bcs_pkg::SQ_OFF;
        end
      end
      bcs_pkg::SQ_OFF: begin
        st_next.disc_req = 1'b0;
      end
      default: begin
        st_next.seq = bcs_pkg::SQ_OFF;
      end
    endcase

    // Power follows the sequence and the hard cut unless the wake input is held
    if (st_next.seq == bcs_pkg::SQ_OFF || st_next.hcut) begin
      st_next.pwr = 1'b0;
    end

    // Held wake defeats shutdown; a closure restarts from off
    if (wake_on) begin
      st_next.seq      = bcs_pkg::SQ_RUN;
      st_next.disc_req = 1'b0;
      st_next.hcut     = 1'b0;
      st_next.pwr      = 1'b1;
    end

    // Factory reset strap caught while startup is flagged
    st_next.fload = startup && frst_on;
    st_next.erase = startup && frst_on;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg     <= '0;
      st_reg.seq <= bcs_pkg::SQ_RUN;
      st_reg.pwr <= 1'b1; // Powered after reset
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state register
  assign clear_fault    = st_reg.clear;
  assign close_permit   = st_reg.permit;
  assign auto_close     = st_reg.auto_cl;
  assign stack_disc_req = st_reg.disc_req;
  assign power_enable   = st_reg.pwr;
  assign hard_power_cut = st_reg.hcut;
  assign factory_load   = st_reg.fload;
  assign config_erase   = st_reg.erase;
  assign gp_out_a       = st_reg.gpo;
  assign gp_in_seen     = st_reg.gpi;
endmodule : bcs_sequencer

/* test/bcs_monitor.sv */
// Assertion checker watching the control input sequencer ports
`timescale 1ns/1ps
module bcs_monitor #(
  parameter int SHORT_CYC = 20,
  parameter int LONG_CYC  = 60
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control and status inputs
  input wire logic fault_clear_n,
  input wire logic shutdown_n,
  input wire logic unit_wake_n,
  input wire logic faults_active,
  input wire logic contactors_open,
  input wire logic service_lockout,
  input wire logic lockout_exit,
  // Outputs under check
  input wire logic clear_fault,
  input wire logic close_permit,
  input wire logic auto_close,
  input wire logic stack_disc_req,
  input wire logic power_enable,
  input wire logic hard_power_cut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // --------------------------------------------------------------------
  // Raw press lengths
  // --------------------------------------------------------------------
  int fc_cnt; // Fault-clear low run
  int sd_cnt; // Shutdown low run
  int sd_len; // Length of last shutdown press
  int wk_cnt; // Wake low run
  // Raw counts are never shorter than the filtered ones
  always_ff @(posedge mclk) begin
    if (reset) begin
      fc_cnt <= 0;
      sd_cnt <= 0;
      sd_len <= 0;
      wk_cnt <= 0;
    end else begin
      fc_cnt <= fault_clear_n ? 0 : fc_cnt + 1;
      sd_cnt <= shutdown_n ? 0 : sd_cnt + 1;
      wk_cnt <= unit_wake_n ? 0 : wk_cnt + 1;
      if (shutdown_n && sd_cnt != 0) begin
        sd_len <= sd_cnt;
      end
    end
  end
  // --------------------------------------------------------------------
  // Steps
  // --------------------------------------------------------------------
  sequence s_grace_start;
    $rose(stack_disc_req);
  endsequence
  sequence s_clear_faulty;
    clear_fault && faults_active ##1 faults_active;
  endsequence
  clr_pulse_a: assert property (clear_fault |=> !clear_fault)
    else $error("fault clear pulse too long");
  clr_delay_a: assert property ($rose(clear_fault) |-> fc_cnt >= SHORT_CYC)
    else $error("fault clear issued early");
  permit_block_a: assert property (s_clear_faulty |-> !close_permit)
    else $error("close permitted with faults");
  auto_close_a: assert property (auto_close |-> $past(clear_fault) && close_permit)
    else $error("auto close out of turn");
  hard_cut_a: assert property ($rose(hard_power_cut) |-> sd_cnt >= LONG_CYC)
    else $error("hard cut before long press");
  grace_len_a: assert property (s_grace_start |->
    sd_len >= SHORT_CYC && sd_len < LONG_CYC)
    else $error("graceful start on wrong press");
  power_order_a: assert property ($fell(power_enable) |->
    ($past(contactors_open) && $past(stack_disc_req)) || $past(service_lockout)
    || $past(lockout_exit) || hard_power_cut)
    else $error("power removed out of order");
  wake_hold_a: assert property (wk_cnt >= 12 |-> power_enable && !hard_power_cut)
    else $error("held wake did not hold power");
endmodule : bcs_monitor

/* test/bcs_plant.sv */
// Stack controller and contactor model answering disconnect requests
`timescale 1ns/1ps
module bcs_plant (
  // Clock
  input  wire logic       mclk,
  // Request and answer pace
  input  wire logic       stack_disc_req,
  input  wire logic [3:0] delay,
  // Answers
  output logic            stack_disc_done,
  output logic            contactors_open
);
  int cnt = 0; // Cycles since request
  initial begin
    stack_disc_done = 1'b0;
    contactors_open = 1'b0;
  end
  // Done after delay, contactors open after twice that; drop with request
  always @(posedge mclk) begin
    cnt <= stack_disc_req ? cnt + 1 : 0;
    stack_disc_done <= stack_disc_req && cnt >= delay;
    contactors_open <= stack_disc_req && cnt >= 2 * delay;
  end
endmodule : bcs_plant

/* test/tb_top.sv */
// Self-checking testbench for the control input sequencer
`timescale 1ns/1ps
module tb_top;
  logic       mclk, reset, startup, faults_active, close_pending;
  logic       service_lockout, lockout_exit, done, copen, req_q;
  logic       clear_fault, close_permit, auto_close, stack_disc_req;
  logic       power_enable, hard_power_cut, factory_load, config_erase;
  logic [3:0] ctl_n, gp_in_k, gp_out_set, gp_out_a, gp_in_seen, dly;
  int         fail_count, comparisons, n_clr, n_auto, n_req;
  // Lanes: 0 fault clear, 1 factory reset, 2 shutdown, 3 wake
  bcs_sequencer #(.SHORT_CYC(20), .LONG_CYC(60), .DEB_CYC(4)) i_bcs_sequencer (
    .mclk(mclk), .reset(reset), .fault_clear_n(ctl_n[0]), .factory_reset_n(ctl_n[1]),
    .shutdown_n(ctl_n[2]), .unit_wake_n(ctl_n[3]), .startup(startup),
    .faults_active(faults_active), .close_pending(close_pending),
    .stack_disc_done(done), .contactors_open(copen), .service_lockout(service_lockout),
    .lockout_exit(lockout_exit), .gp_in_k(gp_in_k), .gp_out_set(gp_out_set),
    .clear_fault(clear_fault), .close_permit(close_permit), .auto_close(auto_close),
    .stack_disc_req(stack_disc_req), .power_enable(power_enable),
    .hard_power_cut(hard_power_cut), .factory_load(factory_load),
    .config_erase(config_erase), .gp_out_a(gp_out_a), .gp_in_seen(gp_in_seen));
  bcs_plant i_bcs_plant (.mclk(mclk), .stack_disc_req(stack_disc_req), .delay(dly),
    .stack_disc_done(done), .contactors_open(copen));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Event counters, request counted on its rising edge
  always @(posedge mclk) begin
    n_clr  <= n_clr + (clear_fault === 1'b1);
    n_auto <= n_auto + (auto_close === 1'b1);
    n_req  <= n_req + (stack_disc_req === 1'b1 && req_q === 1'b0);
    req_q  <= stack_disc_req;
  end
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Closure to the reference drives the lane low for n cycles
  task automatic press(input int i, input int n);
    @(posedge mclk) ctl_n[i] <= 1'b0;
    tick(n);
    ctl_n[i] <= 1'b1;
    tick(15);
  endtask : press
  task automatic wait_pwr(input logic v);
    int k;
    k = 0;
    @(negedge mclk);
    while (power_enable !== v && k < 300) begin
      @(negedge mclk);
      k++;
    end
    chk(power_enable, v);
  endtask : wait_pwr
  task automatic sc_fault_clear;
    int c, a;
    c = n_clr;
    a = n_auto;
    @(posedge mclk) faults_active <= 1'b1;
    close_pending <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge mclk) ctl_n[0] <= ~ctl_n[0];
    end
    press(0, 10);
    @(negedge mclk);
    chk(4'(n_clr - c), 4'h0);
    press(0, 30);
    @(negedge mclk);
    chk(4'(n_clr - c), 4'h1);
    chk({3'h0, close_permit}, 4'h0);
    chk(4'(n_auto - a), 4'h0);
    @(posedge mclk) faults_active <= 1'b0;
    press(0, 30);
    @(negedge mclk);
    chk({3'h0, close_permit}, 4'h1);
    chk(4'(n_auto - a), 4'h1);
  endtask : sc_fault_clear
  task automatic sc_graceful(input logic [3:0] d);
    int r;
    r = n_req;
    @(posedge mclk) dly <= d;
    press(2, 30);
    @(negedge mclk);
    if (d > 4'h8) chk({3'h0, power_enable}, 4'h1);
    wait_pwr(1'b0);
    chk(4'(n_req - r), 4'h1);
    chk({3'h0, hard_power_cut}, 4'h0);
    press(3, 8);
    wait_pwr(1'b1);
  endtask : sc_graceful
  task automatic sc_hard;
    int r;
    r = n_req;
    // Long press only after no graceful start was made
    press(2, 80);
    @(negedge mclk);
    chk({3'h0, hard_power_cut}, 4'h1);
    chk(4'(n_req - r), 4'h0);
    press(3, 8);
    @(negedge mclk);
    chk({3'h0, hard_power_cut}, 4'h0);
    wait_pwr(1'b1);
  endtask : sc_hard
  task automatic sc_lockout(input int i);
    int r;
    r = n_req;
    @(posedge mclk) service_lockout <= (i == 0);
    lockout_exit <= (i == 1);
    press(2, 30);
    wait_pwr(1'b0);
    chk(4'(n_req - r), 4'h0);
    @(posedge mclk) service_lockout <= 1'b0;
    lockout_exit <= 1'b0;
    press(3, 8);
    wait_pwr(1'b1);
  endtask : sc_lockout
  task automatic sc_wake_hold;
    @(posedge mclk) ctl_n[3] <= 1'b0;
    press(2, 80);
    @(negedge mclk);
    chk({2'h0, hard_power_cut, power_enable}, 4'h1);
    @(posedge mclk) ctl_n[3] <= 1'b1;
    tick(15);
  endtask : sc_wake_hold
  task automatic sc_factory_gp;
    @(posedge mclk) startup <= 1'b1;
    ctl_n[1] <= 1'b0;
    tick(12);
    @(negedge mclk);
    chk({2'h0, factory_load, config_erase}, 4'h3);
    @(posedge mclk) startup <= 1'b0;
    tick(3);
    @(negedge mclk);
    chk({2'h0, factory_load, config_erase}, 4'h0);
    @(posedge mclk) ctl_n[1] <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      gp_out_set <= 4'h1 << i;
      gp_in_k <= ~(4'h1 << i);
      @(posedge mclk);
      @(negedge mclk);
      chk(gp_out_a, 4'h1 << i);
      chk(gp_in_seen, 4'h1 << i);
      @(posedge mclk);
    end
  endtask : sc_factory_gp
  task automatic complete_run;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog well beyond the under one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    complete_run();
  end
  initial begin
    {reset, ctl_n, startup, faults_active, close_pending} = {1'b1, 4'hf, 3'h0};
    {service_lockout, lockout_exit, gp_in_k, gp_out_set, dly} = {2'h0, 4'hf, 4'h0, 4'h2};
    {fail_count, comparisons, n_clr, n_auto, n_req} = '0;
    tick(10);
    reset <= 1'b0;
    sc_fault_clear();
    sc_graceful(4'h2);
    sc_graceful(4'h9);
    sc_hard();
    sc_lockout(0);
    sc_lockout(1);
    sc_wake_hold();
    sc_factory_gp();
    complete_run();
  end
endmodule : tb_top
bind bcs_sequencer bcs_monitor #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) i_bcs_monitor (
  .mclk(mclk), .reset(reset), .fault_clear_n(fault_clear_n), .shutdown_n(shutdown_n),
  .unit_wake_n(unit_wake_n), .faults_active(faults_active),
  .contactors_open(contactors_open), .service_lockout(service_lockout),
  .lockout_exit(lockout_exit), .clear_fault(clear_fault), .close_permit(close_permit),
  .auto_close(auto_close), .stack_disc_req(stack_disc_req),
  .power_enable(power_enable), .hard_power_cut(hard_power_cut));
